// ===== include/rssp_pkg.sv
// Shared constants and types of the serial slave port.
// Assumes one 20 MHz clock; bus pins arrive unsynchronised.
package rssp_pkg;

  localparam int          RSSP_ADDR_W     = 4;
  localparam int          RSSP_DATA_W     = 8;
  localparam int          RSSP_DEPTH      = 16;
  // Fixed slave address, bits 7..1 of the address byte
  localparam logic [6:0]  RSSP_SLAVE_ADDR = 7'h51;
  localparam logic [3:0]  RSSP_BYTE_BITS  = 4'h8;
  localparam logic [3:0]  RSSP_CNT_ZERO   = 4'h0;
  localparam logic [3:0]  RSSP_CNT_ONE    = 4'h1;
  localparam logic [3:0]  RSSP_PTR_STEP   = 4'h1;
  localparam logic [3:0]  RSSP_PTR_RST    = 4'h0;
  localparam logic [7:0]  RSSP_BYTE_RST   = 8'h00;
  localparam int          RSSP_RW_BIT     = 0;
  localparam int          RSSP_MSB        = 7;

  // One-hot port states
  typedef enum logic [5:0] {
    RSSP_IDLE = 6'h01,
    RSSP_ADDR = 6'h02,
    RSSP_RX   = 6'h04,
    RSSP_ACK  = 6'h08,
    RSSP_TX   = 6'h10,
    RSSP_MACK = 6'h20
  } rssp_state_t;

  // Request to the register space
  typedef struct packed {
    logic                   we;
    logic [RSSP_ADDR_W-1:0] addr;
    logic [RSSP_DATA_W-1:0] wdata;
  } rssp_mem_req_t;

endpackage : rssp_pkg

// ===== verif/rssp_master.sv
// Bus master model for the two-wire link of the slave port.
// Assumes each frame is begun on a falling clock_in edge.
module rssp_master (
  output logic      scl_out,
  output logic      sda_drv_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: both lines released
  initial begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end
  // One 400 ns bit; data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    #100 sda_drv_out = b;
    #100 scl_out = 1'b1;
    #100 r = sda_in;
    #100 scl_out = 1'b0;
  endtask : bitx
  // Start or repeated start; long low gap lets the slave release
  task automatic start();
    #200 sda_drv_out = 1'b1;
    #100 scl_out = 1'b1;
    #200 sda_drv_out = 1'b0;
    #200 scl_out = 1'b0;
  endtask : start
  // Stop, then bus free time; the clock stays high outside frames
  task automatic stop();
    #100 sda_drv_out = 1'b0;
    #100 scl_out = 1'b1;
    #200 sda_drv_out = 1'b1;
    #400;
  endtask : stop
  // Byte out MSB first, then sample the slave's ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask : wbyte
  // Byte in MSB first, then our own ack or nack
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask : rbyte
endmodule : rssp_master

// ===== verif/tb.sv
// Self-checking bench of the serial slave port against a master model.
// Assumes a 20 MHz clock_in and a 400 ns link clock period.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rssp_pkg::*;
  logic       clock_in   = 1'b0;
  logic       rst_in     = 1'b1;
  logic       reset_n_in = 1'b1;
  logic       scl, m_sda, sda_out, sda_oe_out, busy_out, oe_q, scl_q;
  wire logic  sda;
  logic [7:0] exp_mem [16];
  logic [3:0] ptr;
  int         n_errors  = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  // Open-drain wire with pull-up
  assign sda = (sda_oe_out ? sda_out : 1'b1) & m_sda;
  always #25 clock_in = ~clock_in;
  rssp_port dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out));
  rssp_master m_u (.scl_out(scl), .sda_drv_out(m_sda), .sda_in(sda));
  // Pointer steps and wraps 15 to 0
  function automatic logic [3:0] nxt(input logic [3:0] p);
    return p + 4'h1;
  endfunction : nxt
  function automatic logic [7:0] abyte(input logic rd);
    return {7'b1010001, rd};
  endfunction : abyte
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Address, pointer byte, then n random data bytes
  task automatic wr(input logic [3:0] p, input int n, input logic fin);
    logic       a;
    logic [7:0] d;
    @(negedge clock_in);
    m_u.start();
    m_u.wbyte(abyte(1'b0), a);
    check(8'(a), 8'h00);
    check(8'(busy_out), 8'h01);
    m_u.wbyte({4'h0, p}, a);
    check(8'(a), 8'h00);
    ptr = p;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m_u.wbyte(d, a);
      check(8'(a), 8'h00);
      exp_mem[ptr] = d;
      ptr = nxt(ptr);
    end
    if (fin) begin
      m_u.stop();
      check(8'(busy_out), 8'h00);
    end
  endtask : wr
  // Read n bytes from the current pointer, nack on the last
  task automatic rd(input int n);
    logic       a;
    logic [7:0] d;
    @(negedge clock_in);
    m_u.start();
    m_u.wbyte(abyte(1'b1), a);
    check(8'(a), 8'h00);
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i == n - 1, d);
      check(d, exp_mem[ptr]);
      ptr = nxt(ptr);
    end
    m_u.stop();
    check(8'(busy_out), 8'h00);
  endtask : rd
  // Foreign address: silent on the address and on what follows
  task automatic bad(input logic [7:0] ab);
    logic a;
    @(negedge clock_in);
    m_u.start();
    m_u.wbyte(ab, a);
    check(8'(a), 8'h01);
    m_u.wbyte(8'h00, a);
    check(8'(a), 8'h01);
    m_u.stop();
  endtask : bad
  // Pin monitors and the hang limit
  always @(posedge clock_in) begin
    scl_q <= scl;
    oe_q <= sda_oe_out;
    cycles <= cycles + 1;
    if (!rst_in) check(8'(sda_oe_out & sda), 8'h00);
    if (!rst_in && scl && scl_q) check(8'(sda_oe_out), 8'(oe_q));
    if (cycles == 40000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  // Main sequence
  initial begin
    logic       a;
    logic [6:0] wa;
    void'($urandom(32'h716d1f8e));
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    wr(4'h0, 16, 1'b1);
    rd(16);
    wr(4'he, 4, 1'b1);
    wr(4'he, 0, 1'b0);
    rd(4);
    // Random writes, then pointer set and repeated-start reads
    repeat (6) begin
      wr(4'($urandom), 1 + $urandom % 4, 1'b1);
      wr(4'($urandom), 0, 1'b0);
      rd(1 + $urandom % 5);
    end
    // Near-miss addresses first, then random foreign ones
    bad(8'ha0);
    bad(8'ha7);
    bad(8'h23);
    repeat (4) begin
      do wa = 7'($urandom); while (wa == 7'h51);
      bad({wa, 1'($urandom)});
    end
    rd(2);
    // Port reset in mid-transfer keeps the register data
    @(negedge clock_in);
    m_u.start();
    m_u.wbyte(abyte(1'b0), a);
    @(posedge clock_in) reset_n_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check(8'(busy_out), 8'h00);
    @(negedge clock_in);
    m_u.stop();
    ptr = 4'h0;
    rd(16);
    end_sim();
  end
endmodule : tb

// ===== verilog/rssp_mem.sv
// Register space reached through the serial port.
// Assumes one clock; contents survive any port reset on purpose.
module rssp_mem (
  input  wire logic                           clock_in,
  input  wire rssp_pkg::rssp_mem_req_t        req_in,
  output logic [rssp_pkg::RSSP_DATA_W-1:0]    rdata_out
);
  import rssp_pkg::*;

  logic [RSSP_DATA_W-1:0] store_reg [RSSP_DEPTH];
  logic [RSSP_DATA_W-1:0] rdata_next;

  // Read data always follows the address
  always_comb begin
    rdata_next = store_reg[req_in.addr];
  end

  // No reset: time-keeping contents are kept
  always_ff @(posedge clock_in) begin
    if (req_in.we) begin
      store_reg[req_in.addr] <= req_in.wdata;
    end
    rdata_out <= rdata_next;
  end

endmodule : rssp_mem

// ===== verilog/rssp_port.sv
// Two-wire serial slave port in front of a 16-byte register space.
// Assumes SCL, SDA and the reset pin are asynchronous to clock_in.
//
// How it works
// - First byte after start is the address
// - Slave only; never makes clock or conditions
// - SCL input only; SDA only pulled low
// - Address 1010001 then read/write bit
// - Read sends data right after address ack
// - Register pointer steps after every data byte
// - Ack own address on ninth clock
// - Ack every received byte as receiver
// - Start and stop seen while SCL high
// - Reset pin clears port, not register data
module rssp_port (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic reset_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      busy_out
);
  import rssp_pkg::*;

  // Pin synchronisers and edge history
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic rstn_meta, rstn_sync;
  logic scl_rise, scl_fall, bus_start, bus_stop, port_reset;

  rssp_state_t         state_reg, state_next;
  logic [3:0]          cnt_reg, cnt_next;
  logic [7:0]          shift_reg, shift_next;
  logic [3:0]          ptr_reg, ptr_next;
  logic                rw_reg, rw_next;
  logic                ptr_set_reg, ptr_set_next;
  logic                oe_reg, oe_next;
  logic                mack_reg, mack_next;
  logic                busy_reg, busy_next;
  rssp_mem_req_t       mem_req;
  logic [7:0]          mem_rdata;

  // Two flops per pin before anything looks at it
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_meta  <= 1'b1;
      scl_sync  <= 1'b1;
      scl_prev  <= 1'b1;
      sda_meta  <= 1'b1;
      sda_sync  <= 1'b1;
      sda_prev  <= 1'b1;
      rstn_meta <= 1'b1;
      rstn_sync <= 1'b1;
    end else begin
      scl_meta  <= scl_in;
      scl_sync  <= scl_meta;
      scl_prev  <= scl_sync;
      sda_meta  <= sda_in;
      sda_sync  <= sda_meta;
      sda_prev  <= sda_sync;
      rstn_meta <= reset_n_in;
      rstn_sync <= rstn_meta;
    end
  end

  // Bus events; conditions need SCL high both samples
  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign bus_start  = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign bus_stop   = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign port_reset = ~rstn_sync;

  // Port sequencer: slave only, reacts to master edges
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    ptr_set_next = ptr_set_reg;
    oe_next      = oe_reg;
    mack_next    = mack_reg;
    mem_req      = '0;
    mem_req.addr = ptr_reg;
    if (port_reset) begin
      state_next   = RSSP_IDLE;
      cnt_next     = RSSP_CNT_ZERO;
      ptr_next     = RSSP_PTR_RST;
      ptr_set_next = 1'b0;
      oe_next      = 1'b0;
      mack_next    = 1'b0;
    end else if (bus_stop) begin
      state_next = RSSP_IDLE;
      oe_next    = 1'b0;
    end else if (bus_start) begin
      state_next   = RSSP_ADDR;
      cnt_next     = RSSP_CNT_ZERO;
      oe_next      = 1'b0;
      ptr_set_next = 1'b0;
    end else begin
      unique case (state_reg)
        RSSP_IDLE: begin
          oe_next = 1'b0;
        end
        RSSP_ADDR, RSSP_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_sync};
            cnt_next   = cnt_reg + RSSP_CNT_ONE;
          end else if (scl_fall && cnt_reg == RSSP_BYTE_BITS) begin
            cnt_next = RSSP_CNT_ZERO;
            if (state_reg == RSSP_ADDR) begin
              // Foreign address: stay off the bus until next start
              if (shift_reg[7:1] == RSSP_SLAVE_ADDR) begin
                oe_next    = 1'b1;
                rw_next    = shift_reg[RSSP_RW_BIT];
                state_next = RSSP_ACK;
              end else begin
                state_next = RSSP_IDLE;
              end
            end else begin
              oe_next    = 1'b1;
              state_next = RSSP_ACK;
              if (!ptr_set_reg) begin
                ptr_next     = shift_reg[RSSP_ADDR_W-1:0];
                ptr_set_next = 1'b1;
              end else begin
                mem_req.we    = 1'b1;
                mem_req.wdata = shift_reg;
                ptr_next      = ptr_reg + RSSP_PTR_STEP;
              end
            end
          end
        end
        RSSP_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              state_next = RSSP_TX;
              shift_next = mem_rdata;
              oe_next    = ~mem_rdata[RSSP_MSB];
              cnt_next   = RSSP_CNT_ONE;
            end else begin
              state_next = RSSP_RX;
              oe_next    = 1'b0;
            end
          end
        end
        RSSP_TX: begin
          if (scl_fall) begin
            if (cnt_reg == RSSP_BYTE_BITS) begin
              oe_next    = 1'b0;
              mack_next  = 1'b0;
              state_next = RSSP_MACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[RSSP_MSB-1];
              cnt_next   = cnt_reg + RSSP_CNT_ONE;
            end
          end
        end
        RSSP_MACK: begin
          if (scl_rise) begin
            ptr_next = ptr_reg + RSSP_PTR_STEP;
            if (sda_sync) begin
              state_next = RSSP_IDLE;
            end else begin
              mack_next = 1'b1;
            end
          end else if (scl_fall && mack_reg) begin
            // Pointer moved a full SCL phase ago; read data is settled
            state_next = RSSP_TX;
            shift_next = mem_rdata;
            oe_next    = ~mem_rdata[RSSP_MSB];
            cnt_next   = RSSP_CNT_ONE;
            mack_next  = 1'b0;
          end
        end
        default: begin
          state_next = RSSP_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
    busy_next = (state_next != RSSP_IDLE);
  end

  // Port state registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg   <= RSSP_IDLE;
      cnt_reg     <= RSSP_CNT_ZERO;
      shift_reg   <= RSSP_BYTE_RST;
      ptr_reg     <= RSSP_PTR_RST;
      rw_reg      <= 1'b0;
      ptr_set_reg <= 1'b0;
      oe_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      rw_reg      <= rw_next;
      ptr_set_reg <= ptr_set_next;
      oe_reg      <= oe_next;
      mack_reg    <= mack_next;
      busy_reg    <= busy_next;
    end
  end

  // Open drain: level is always low, only the enable moves
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_reg;
  assign busy_out   = busy_reg;

  rssp_mem u_mem (
    .clock_in  (clock_in),
    .req_in    (mem_req),
    .rdata_out (mem_rdata)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_idle_no_drive: assert property (
    (state_reg == RSSP_IDLE || state_reg == RSSP_ADDR) |-> !oe_reg)
    else $error("SDA driven while not addressed");
  chk_start_to_addr: assert property (
    (rstn_sync && bus_start) |=> (state_reg == RSSP_ADDR && cnt_reg == 0))
    else $error("Start not followed by address phase");
  chk_addr_match_ack: assert property (
    (state_reg == RSSP_ADDR && scl_fall && cnt_reg == RSSP_BYTE_BITS
     && rstn_sync && !bus_start && !bus_stop
     && shift_reg[7:1] == RSSP_SLAVE_ADDR)
    |=> (oe_reg && state_reg == RSSP_ACK))
    else $error("Own address not acknowledged");
  chk_addr_miss_idle: assert property (
    (state_reg == RSSP_ADDR && scl_fall && cnt_reg == RSSP_BYTE_BITS
     && rstn_sync && !bus_start && !bus_stop
     && shift_reg[7:1] != RSSP_SLAVE_ADDR)
    |=> (!oe_reg && state_reg == RSSP_IDLE))
    else $error("Foreign address answered");
  chk_rx_byte_ack: assert property (
    (state_reg == RSSP_RX && scl_fall && cnt_reg == 4'h8 && rstn_sync
     && !bus_start && !bus_stop) |=> oe_reg)
    else $error("Received byte not acknowledged");
  chk_read_starts: assert property (
    (state_reg == RSSP_ACK && rw_reg && scl_fall && rstn_sync
     && !bus_start && !bus_stop)
    |=> (state_reg == RSSP_TX && oe_reg == !$past(mem_rdata[7])))
    else $error("Read data not started after ack");
  chk_write_steps: assert property (
    mem_req.we |=> (ptr_reg == $past(ptr_reg) + 4'h1))
    else $error("Pointer did not step after write");
  chk_first_loads: assert property (
    (state_reg == RSSP_RX && !ptr_set_reg && scl_fall && cnt_reg == 4'h8
     && rstn_sync && !bus_start && !bus_stop)
    |=> (ptr_set_reg && ptr_reg == $past(shift_reg[3:0])))
    else $error("First written byte did not load pointer");
  chk_pin_reset: assert property (
    !rstn_sync |=> (state_reg == RSSP_IDLE && !oe_reg && !busy_reg))
    else $error("Reset pin did not idle the port");

  cov_addr_ack:  cover property (state_reg == RSSP_ADDR ##[1:100]
                                 state_reg == RSSP_ACK);
  cov_write:     cover property (mem_req.we);
  cov_read_more: cover property (state_reg == RSSP_MACK && mack_reg);
  cov_read_nack: cover property (state_reg == RSSP_MACK ##1
                                 state_reg == RSSP_IDLE);

endmodule : rssp_port
